// ===== hw/safety_load_pkg.sv
package safety_load_pkg;
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OBJ_DATA = 8'h04;
    localparam logic [7:0] A_OBJ_CMD = 8'h08;
    localparam logic [7:0] A_STATE = 8'h0C;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_IEN = 8'h14;
    localparam logic [7:0] A_ICLR = 8'h18;
    localparam logic [7:0] A_PW_KEY = 8'h1C;
    localparam logic [7:0] A_SAFE_ADDR = 8'h20;
    localparam logic [7:0] A_LOG_NAME = 8'h24;
    localparam logic [7:0] A_LOG_TIME = 8'h28;
    localparam logic [7:0] A_LOG_CNT = 8'h2C;
    // Control event bits
    localparam int C_FILE_OK = 0;
    localparam int C_FILE_BAD = 1;
    localparam int C_FS_OK = 2;
    localparam int C_FS_BAD = 3;
    localparam int C_FS_RST = 4;
    localparam int C_CLEAR = 5;
    // Status / interrupt bits
    localparam int NIRQ = 4;
    localparam int S_FILE_ERR = 0;
    localparam int S_ABORT = 1;
    localparam int S_VALID = 2;
    localparam int S_FS_OK = 3;
    // Monitor state codes as seen by the master
    localparam logic [3:0] CODE_CFG = 4'h3;
    localparam logic [3:0] CODE_VAL = 4'h5;
    localparam logic [3:0] CODE_RUN = 4'h6;
    // Object dictionary
    localparam logic [15:0] OD_VALIDATE = 16'h37C0;
    localparam logic [15:0] OD_STATE = 16'h37C1;
    localparam logic [7:0] SUB_STATE = 8'h00;
    localparam logic [7:0] SUB_NAME = 8'h01;
    localparam logic [7:0] SUB_TIME = 8'h02;
    localparam logic [7:0] SUB_ADDR = 8'h03;
    localparam logic [7:0] SUB_PW = 8'h04;
    // Object string lengths in characters
    localparam logic [7:0] NAME_MIN = 8'h01;
    localparam logic [7:0] NAME_MAX = 8'h08;
    localparam logic [7:0] TIME_LEN = 8'h14;
    localparam logic [7:0] PW_MIN = 8'h08;
    localparam logic [7:0] PW_MAX = 8'h19;
    // Reset values
    localparam logic [31:0] PW_KEY_RST = 32'h0000_0000;
    localparam logic [31:0] SAFE_ADDR_RST = 32'h0000_0001;
    typedef enum logic [1:0] {CFG_REQ, VAL_REQ, RUN} mon_t;
endpackage

// ===== hw/safety_param_load_validate.sv
`timescale 1ns/1ps
// Function
// - Bad package flags error, stay state 3
// - Good package moves state 3 to 5
// - Monitor state readable in register 0x0C; writes to object 0x37C1 abort
// - Object writes validate, only in state 5
// - Name 1 to 8 chars, logged
// - Timestamp 20 chars UTC, logged
// - Password 8 to 25 chars authorises
// - Success enters state 6, activates config
// - Failure aborts, stays state 5, inactive
// - File-loaded config stored persistently
// - Fail-safe validation from 3 to 6
// - Fail-safe config lost on reboot or reset
module safety_param_load_validate (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic NVM_VALID,
    output logic NVM_STORE,
    output logic NVM_ERASE,
    output logic CONFIG_ACTIVE,
    output logic CONFIG_PERSIST,
    output logic [3:0] STATE_CODE,
    output logic IRQ
);
    // One clock domain for every check, all of them quiet during reset
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // Inclusive length window check, used for the name and password objects
    function automatic logic len_ok(input logic [7:0] len, input logic [7:0] lo,
                                    input logic [7:0] hi);
        len_ok = (len >= lo) && (len <= hi);
    endfunction

    safety_load_pkg::mon_t mon, next_mon; // Monitor state
    logic persist, next_persist; // Active config is stored
    logic [1:0] step, next_step; // Objects accepted so far
    logic addr_ok, next_addr_ok; // Safety address matched
    logic [31:0] obj_data, next_obj_data; // Staged object value
    logic [31:0] pw_key, next_pw_key; // Password digest
    logic [31:0] safe_addr, next_safe_addr; // Own safety address
    logic [31:0] pend_name, next_pend_name; // Name awaiting log
    logic [31:0] pend_time, next_pend_time; // Time awaiting log
    logic [31:0] log_name, next_log_name; // Last logged name
    logic [31:0] log_time, next_log_time; // Last logged time
    logic [7:0] log_cnt, next_log_cnt; // Successful validations
    logic [safety_load_pkg::NIRQ-1:0] stat, next_stat; // Sticky events
    logic [safety_load_pkg::NIRQ-1:0] ien, next_ien; // Interrupt enables
    logic boot, next_boot; // First cycle after reset
    logic nvm_store, next_nvm_store;
    logic nvm_erase, next_nvm_erase;
    logic [31:0] rdata, next_rdata;
    logic nvm_meta, nvm_sync; // Pin synchroniser
    // Combinational helpers
    logic wr, obj_wr, abort, success;
    logic [5:0] ctl;
    logic [safety_load_pkg::NIRQ-1:0] set_ev, clr_ev;
    logic [15:0] idx;
    logic [7:0] len, sub;

    // Decoded fields of the object command word, write strobes and control events
    assign idx = PWDATA[31:16];
    assign len = PWDATA[15:8];
    assign sub = PWDATA[7:0];
    assign wr = PSEL && PENABLE && PWRITE;
    assign obj_wr = wr && (PADDR == safety_load_pkg::A_OBJ_CMD);
    assign ctl = (wr && (PADDR == safety_load_pkg::A_CTRL)) ? PWDATA[5:0] : 6'h00;

    // Object write decision; an abort is answered with PSLVERR
    always_comb begin
        abort = 1'b0;
        success = 1'b0;
        if (obj_wr) begin
            if (idx == safety_load_pkg::OD_STATE) begin
                abort = 1'b1; // State object is read only
            end else if (idx != safety_load_pkg::OD_VALIDATE) begin
                abort = 1'b1; // Unknown object
            end else if (mon != safety_load_pkg::VAL_REQ) begin
                abort = 1'b1;
            end else if (sub != {6'h00, step} + 8'h01) begin
                abort = 1'b1;
            end else begin
                unique case (sub)
                    safety_load_pkg::SUB_NAME:
                        abort = !len_ok(len, safety_load_pkg::NAME_MIN,
                                        safety_load_pkg::NAME_MAX);
                    safety_load_pkg::SUB_TIME:
                        abort = (len != safety_load_pkg::TIME_LEN);
                    safety_load_pkg::SUB_ADDR:
                        abort = (obj_data != safe_addr);
                    default: begin
                        // Password closes the sequence
                        success = len_ok(len, safety_load_pkg::PW_MIN,
                                         safety_load_pkg::PW_MAX)
                                  && (obj_data == pw_key) && addr_ok;
                        abort = !success;
                    end
                endcase
            end
        end
    end

    // Next values of all state except the pin synchroniser
    always_comb begin
        next_mon = mon;
        next_persist = persist;
        next_step = step;
        next_addr_ok = addr_ok;
        next_obj_data = obj_data;
        next_pw_key = pw_key;
        next_safe_addr = safe_addr;
        next_pend_name = pend_name;
        next_pend_time = pend_time;
        next_log_name = log_name;
        next_log_time = log_time;
        next_log_cnt = log_cnt;
        next_ien = ien;
        next_boot = 1'b0;
        next_nvm_store = 1'b0;
        next_nvm_erase = 1'b0;
        set_ev = '0;
        clr_ev = '0;
        next_rdata = 32'h0000_0000;
        // Reboot restores only a stored config
        if (boot && nvm_sync) begin
            next_mon = safety_load_pkg::RUN;
            next_persist = 1'b1;
        end
        // Plain register writes
        if (wr) begin
            unique case (PADDR)
                safety_load_pkg::A_OBJ_DATA: next_obj_data = PWDATA;
                safety_load_pkg::A_IEN: next_ien = PWDATA[safety_load_pkg::NIRQ-1:0];
                safety_load_pkg::A_ICLR: clr_ev = PWDATA[safety_load_pkg::NIRQ-1:0];
                safety_load_pkg::A_PW_KEY: next_pw_key = PWDATA;
                safety_load_pkg::A_SAFE_ADDR: next_safe_addr = PWDATA;
                default: ;
            endcase
        end
        // Package transfer result, accepted only while unconfigured
        if (mon == safety_load_pkg::CFG_REQ) begin
            if (ctl[safety_load_pkg::C_FILE_BAD]) begin
                set_ev[safety_load_pkg::S_FILE_ERR] = 1'b1;
            end else if (ctl[safety_load_pkg::C_FILE_OK]) begin
                next_mon = safety_load_pkg::VAL_REQ;
                next_step = 2'h0;
                next_addr_ok = 1'b0;
            end else if (ctl[safety_load_pkg::C_FS_OK]) begin
                next_mon = safety_load_pkg::RUN;
                next_persist = 1'b0;
                set_ev[safety_load_pkg::S_FS_OK] = 1'b1;
            end
        end
        // Object sequence progress
        if (obj_wr && abort) begin
            set_ev[safety_load_pkg::S_ABORT] = 1'b1;
            next_step = 2'h0; // A failed write restarts the sequence
            next_addr_ok = 1'b0;
        end else if (obj_wr) begin
            next_step = step + 2'h1;
            if (sub == safety_load_pkg::SUB_NAME) begin
                next_pend_name = obj_data;
            end
            if (sub == safety_load_pkg::SUB_TIME) begin
                next_pend_time = obj_data;
            end
            if (sub == safety_load_pkg::SUB_ADDR) begin
                next_addr_ok = 1'b1;
            end
        end
        if (success) begin
            next_mon = safety_load_pkg::RUN;
            next_persist = 1'b1;
            next_nvm_store = 1'b1;
            next_log_name = pend_name;
            next_log_time = pend_time;
            next_log_cnt = log_cnt + 8'h01;
            set_ev[safety_load_pkg::S_VALID] = 1'b1;
        end
        // Fail-safe connection reset drops a volatile config
        if (ctl[safety_load_pkg::C_FS_RST] && !persist) begin
            next_mon = safety_load_pkg::CFG_REQ;
        end
        // Clearing the stored config wins over every other monitor state change
        if (ctl[safety_load_pkg::C_CLEAR]) begin
            next_mon = safety_load_pkg::CFG_REQ;
            next_persist = 1'b0;
            next_nvm_erase = 1'b1;
        end
        // Read data sampled in the setup phase
        if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                safety_load_pkg::A_OBJ_DATA: next_rdata = obj_data;
                safety_load_pkg::A_STATE: next_rdata = {28'h0000000, STATE_CODE};
                safety_load_pkg::A_STAT: next_rdata = {28'h0000000, stat};
                safety_load_pkg::A_IEN: next_rdata = {28'h0000000, ien};
                safety_load_pkg::A_PW_KEY: next_rdata = pw_key;
                safety_load_pkg::A_SAFE_ADDR: next_rdata = safe_addr;
                safety_load_pkg::A_LOG_NAME: next_rdata = log_name;
                safety_load_pkg::A_LOG_TIME: next_rdata = log_time;
                safety_load_pkg::A_LOG_CNT: next_rdata = {24'h000000, log_cnt};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        // Set wins over a clear in the same cycle
        next_stat = (stat & ~clr_ev) | set_ev;
    end

    // Register stage
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mon <= safety_load_pkg::CFG_REQ;
            persist <= 1'b0;
            step <= 2'h0;
            addr_ok <= 1'b0;
            obj_data <= 32'h0000_0000;
            pw_key <= safety_load_pkg::PW_KEY_RST;
            safe_addr <= safety_load_pkg::SAFE_ADDR_RST;
            pend_name <= 32'h0000_0000;
            pend_time <= 32'h0000_0000;
            log_name <= 32'h0000_0000;
            log_time <= 32'h0000_0000;
            log_cnt <= 8'h00;
            stat <= '0;
            ien <= '0;
            boot <= 1'b1;
            nvm_store <= 1'b0;
            nvm_erase <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            mon <= next_mon;
            persist <= next_persist;
            step <= next_step;
            addr_ok <= next_addr_ok;
            obj_data <= next_obj_data;
            pw_key <= next_pw_key;
            safe_addr <= next_safe_addr;
            pend_name <= next_pend_name;
            pend_time <= next_pend_time;
            log_name <= next_log_name;
            log_time <= next_log_time;
            log_cnt <= next_log_cnt;
            stat <= next_stat;
            ien <= next_ien;
            boot <= next_boot;
            nvm_store <= next_nvm_store;
            nvm_erase <= next_nvm_erase;
            rdata <= next_rdata;
        end
    end

    // Store-valid pin synchroniser, free running so it is settled at release
    always_ff @(posedge CLOCK) begin
        nvm_meta <= NVM_VALID;
        nvm_sync <= nvm_meta;
    end

    // Outputs
    assign PREADY = 1'b1; // Zero wait states
    assign PSLVERR = obj_wr && abort; // Abort answer
    assign PRDATA = rdata;
    assign NVM_STORE = nvm_store;
    assign NVM_ERASE = nvm_erase;
    assign CONFIG_ACTIVE = (mon == safety_load_pkg::RUN);
    assign CONFIG_PERSIST = persist;
    assign STATE_CODE = (mon == safety_load_pkg::RUN) ? safety_load_pkg::CODE_RUN :
                        (mon == safety_load_pkg::VAL_REQ) ? safety_load_pkg::CODE_VAL :
                        safety_load_pkg::CODE_CFG;
    assign IRQ = |(stat & ien);

    // Checks

    file_bad_a: assert property (mon == safety_load_pkg::CFG_REQ
        && ctl[safety_load_pkg::C_FILE_BAD] && !ctl[safety_load_pkg::C_CLEAR]
        |=> STATE_CODE == 4'h3 && stat[safety_load_pkg::S_FILE_ERR])
        else $error("bad package left state 3");
    file_ok_a: assert property (mon == safety_load_pkg::CFG_REQ && ctl == 6'h01
        |=> STATE_CODE == 4'h5)
        else $error("good package did not reach state 5");
    state_read_a: assert property (PSEL && !PENABLE && !PWRITE
        && PADDR == safety_load_pkg::A_STATE ##1 PENABLE |-> PRDATA[3:0] == STATE_CODE)
        else $error("state read mismatch");
    reject_a: assert property (obj_wr && mon != safety_load_pkg::VAL_REQ
        && ctl == 6'h00 |-> PSLVERR ##1 mon == $past(mon))
        else $error("write outside state 5 accepted");
    order_a: assert property (obj_wr && idx == safety_load_pkg::OD_VALIDATE
        && sub != {6'h00, step} + 8'h01 |-> PSLVERR)
        else $error("out of order object accepted");
    name_len_a: assert property (obj_wr && sub == safety_load_pkg::SUB_NAME
        && (len == 8'h00 || len > 8'h08) |-> PSLVERR)
        else $error("bad name length accepted");
    success_a: assert property (success && ctl == 6'h00 |=> STATE_CODE == 4'h6
        && NVM_STORE && CONFIG_PERSIST && log_cnt == $past(log_cnt) + 8'h01)
        else $error("validation success not applied");
    fail_stay_a: assert property (obj_wr && sub == safety_load_pkg::SUB_PW
        && mon == safety_load_pkg::VAL_REQ && PSLVERR && ctl == 6'h00
        |=> STATE_CODE == 4'h5 && !CONFIG_ACTIVE)
        else $error("failed validation left state 5");
    fs_ok_a: assert property (mon == safety_load_pkg::CFG_REQ && ctl == 6'h04
        |=> STATE_CODE == 4'h6 && !CONFIG_PERSIST && !NVM_STORE)
        else $error("fail-safe load wrong");
    fs_rst_a: assert property (CONFIG_ACTIVE && !persist && ctl[safety_load_pkg::C_FS_RST]
        |=> STATE_CODE == 4'h3 ##1 !CONFIG_ACTIVE)
        else $error("volatile config survived reset");

    file_path_c: cover property (mon == safety_load_pkg::VAL_REQ ##[1:40] success);
    fs_path_c: cover property (ctl[safety_load_pkg::C_FS_OK] ##1 CONFIG_ACTIVE);
    abort_c: cover property (obj_wr && abort && sub == safety_load_pkg::SUB_PW);
endmodule // safety_param_load_validate

// ===== verif/nvm_store_model.sv
`timescale 1ns/1ps
// Behavioural nonvolatile store on the far side of the block
module nvm_store_model (
    input wire logic CLOCK,
    input wire logic STORE,
    input wire logic ERASE,
    output logic VALID
);
    logic kept = 1'b0; // Stored-config flag, survives bench resets like real flash
    // Erase wins, so a clear never leaves stale config behind
    always @(posedge CLOCK) begin
        if (ERASE === 1'b1) begin
            kept <= 1'b0;
        end else if (STORE === 1'b1) begin
            kept <= 1'b1;
        end
    end
    assign VALID = kept;
endmodule // nvm_store_model

// ===== verif/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", n, e, a); end end
module tb;
    typedef struct {logic [31:0] d; logic e; logic cd;} note_t; // One expected answer
    note_t notes[$]; // Oldest first
    note_t n;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, nvm_valid, nvm_store, nvm_erase, active, persist, irq;
    logic [3:0] state_code;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int stores = 0;
    int erases = 0;
    int seed = 32'h78cf;
    logic [31:0] pw, sa, nm, tm; // Random key, address, name and time digests

    safety_param_load_validate u_safety_param_load_validate (
        .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .NVM_VALID(nvm_valid), .NVM_STORE(nvm_store),
        .NVM_ERASE(nvm_erase), .CONFIG_ACTIVE(active), .CONFIG_PERSIST(persist),
        .STATE_CODE(state_code), .IRQ(irq)
    );
    nvm_store_model u_nvm_store_model (
        .CLOCK(clock), .STORE(nvm_store), .ERASE(nvm_erase), .VALID(nvm_valid)
    );

    initial forever #2 clock = ~clock;

    // Monitor: takes the oldest note at each completed access, counts store pulses
    always @(posedge clock) begin
        cycles++;
        if (nvm_store === 1'b1) stores++;
        if (nvm_erase === 1'b1) erases++;
        if (psel && penable && pready === 1'b1) begin
            n = notes.pop_front();
            `CHK("pslverr", n.e, pslverr)
            if (n.cd) `CHK("prdata", n.d, prdata)
        end
        // Whole run needs well under a thousand cycles
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] ed, input logic ee);
        notes.push_back('{ed, ee, !w});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock); // Idle gap so no strobe is driven twice in one step
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0000_0000, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000, e, 1'b0);
    endtask
    // Stage the value, then issue the object command
    task automatic obj(input logic [7:0] sub, input logic [7:0] len, input logic [31:0] d,
                       input logic ee);
        wr(safety_load_pkg::A_OBJ_DATA, d);
        xfer(1'b1, safety_load_pkg::A_OBJ_CMD, {safety_load_pkg::OD_VALIDATE, len, sub},
             32'h0000_0000, ee);
    endtask
    // Monitor state through register and pins, settled off the edge
    task automatic st(input logic [3:0] e, input logic ie);
        rd(safety_load_pkg::A_STATE, {28'h0000000, e});
        #1;
        `CHK("state_code", e, state_code)
        `CHK("irq", ie, irq)
        `CHK("config_active", (e === safety_load_pkg::CODE_RUN), active)
        @(posedge clock);
    endtask
    task automatic boot();
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        pw = $random(seed);
        sa = $random(seed);
        nm = $random(seed);
        tm = $random(seed);
        boot();
        st(safety_load_pkg::CODE_CFG, 1'b0);
        rd(safety_load_pkg::A_SAFE_ADDR, safety_load_pkg::SAFE_ADDR_RST);
        rd(safety_load_pkg::A_PW_KEY, safety_load_pkg::PW_KEY_RST);
        rd(8'h40, 32'h0000_0000); // Unmapped reads zero
        $display("defaults test done");
        // Corrupted package, then a good one
        wr(safety_load_pkg::A_IEN, 32'h0000_000F);
        wr(safety_load_pkg::A_CTRL, 32'h0000_0002);
        rd(safety_load_pkg::A_STAT, 32'h0000_0001);
        st(safety_load_pkg::CODE_CFG, 1'b1);
        wr(safety_load_pkg::A_ICLR, 32'h0000_0001);
        st(safety_load_pkg::CODE_CFG, 1'b0);
        wr(safety_load_pkg::A_CTRL, 32'h0000_0001);
        st(safety_load_pkg::CODE_VAL, 1'b0);
        $display("file load test done");
        // Failing validation attempts, interrupt masked
        wr(safety_load_pkg::A_IEN, 32'h0000_0000);
        wr(safety_load_pkg::A_PW_KEY, pw);
        wr(safety_load_pkg::A_SAFE_ADDR, sa);
        rd(safety_load_pkg::A_PW_KEY, pw);
        obj(safety_load_pkg::SUB_NAME, 8'h09, nm, 1'b1);
        obj(safety_load_pkg::SUB_NAME, 8'h00, nm, 1'b1);
        obj(safety_load_pkg::SUB_TIME, safety_load_pkg::TIME_LEN, tm, 1'b1);
        obj(safety_load_pkg::SUB_NAME, 8'h01, nm, 1'b0);
        obj(safety_load_pkg::SUB_TIME, 8'h13, tm, 1'b1);
        obj(safety_load_pkg::SUB_NAME, 8'h08, nm, 1'b0);
        obj(safety_load_pkg::SUB_TIME, safety_load_pkg::TIME_LEN, tm, 1'b0);
        obj(safety_load_pkg::SUB_ADDR, 8'h04, sa, 1'b0);
        obj(safety_load_pkg::SUB_PW, safety_load_pkg::PW_MAX, pw ^ 32'h1, 1'b1);
        rd(safety_load_pkg::A_STAT, 32'h0000_0002);
        st(safety_load_pkg::CODE_VAL, 1'b0);
        $display("failed validation test done");
        // Full good sequence
        obj(safety_load_pkg::SUB_NAME, safety_load_pkg::NAME_MAX, nm, 1'b0);
        obj(safety_load_pkg::SUB_TIME, safety_load_pkg::TIME_LEN, tm, 1'b0);
        obj(safety_load_pkg::SUB_ADDR, 8'h04, sa, 1'b0);
        obj(safety_load_pkg::SUB_PW, safety_load_pkg::PW_MIN, pw, 1'b0);
        st(safety_load_pkg::CODE_RUN, 1'b0);
        rd(safety_load_pkg::A_LOG_NAME, nm);
        rd(safety_load_pkg::A_LOG_TIME, tm);
        rd(safety_load_pkg::A_LOG_CNT, 32'h0000_0001);
        `CHK("stores", 1, stores)
        `CHK("persist", 1'b1, persist)
        obj(safety_load_pkg::SUB_NAME, 8'h01, nm, 1'b1);
        st(safety_load_pkg::CODE_RUN, 1'b0);
        boot();
        st(safety_load_pkg::CODE_RUN, 1'b0);
        $display("validation and reboot test done");
        // Fail-safe path after clearing the stored config
        wr(safety_load_pkg::A_CTRL, 32'h0000_0020);
        st(safety_load_pkg::CODE_CFG, 1'b0);
        `CHK("erases", 1, erases)
        wr(safety_load_pkg::A_CTRL, 32'h0000_0008);
        st(safety_load_pkg::CODE_CFG, 1'b0);
        wr(safety_load_pkg::A_CTRL, 32'h0000_0004);
        st(safety_load_pkg::CODE_RUN, 1'b0);
        `CHK("persist", 1'b0, persist)
        wr(safety_load_pkg::A_CTRL, 32'h0000_0010);
        st(safety_load_pkg::CODE_CFG, 1'b0);
        wr(safety_load_pkg::A_CTRL, 32'h0000_0004);
        boot();
        st(safety_load_pkg::CODE_CFG, 1'b0);
        $display("fail-safe test done");
        give_verdict();
    end
endmodule // tb
